// *** dabs_pkg.sv ***
// constants and carrier types for the dual converter output bus block
package dabs_pkg;

  // ----------------------------------------------------------------
  // word widths
  // ----------------------------------------------------------------
  localparam int unsigned DABS_WORD_W = 10;

  // ----------------------------------------------------------------
  // latency in half periods of the conversion clock
  // ----------------------------------------------------------------
  localparam int unsigned DABS_LAT_I_HALF = 5;
  localparam int unsigned DABS_LAT_Q_HALF = 6;
  // falling-edge stages before the first-channel word leaves
  localparam int unsigned DABS_PIPE_DEPTH = DABS_LAT_I_HALF / 2 + 1;
  localparam int unsigned DABS_PIPE_LAST = DABS_PIPE_DEPTH - 1;

  // ----------------------------------------------------------------
  // conversion clock range expected from the clock source
  // ----------------------------------------------------------------
  localparam int unsigned DABS_SYS_CLK_HZ = 200_000_000;
  localparam int unsigned DABS_CONV_MIN_HZ = 1_000_000;
  localparam int unsigned DABS_CONV_MAX_HZ = 30_000_000;
  localparam int unsigned DABS_CONV_RATED_HZ = 20_000_000;
  // shortest conversion clock period in system cycles, rounded down
  localparam int unsigned DABS_CONV_MIN_PERIOD_CYC = DABS_SYS_CLK_HZ / DABS_CONV_MAX_HZ;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DABS_WORD_W-1:0] DABS_WORD_RST = 10'h000;
  localparam logic [DABS_WORD_W-1:0] DABS_BUS_LOW = 10'h000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef logic [DABS_WORD_W-1:0] dabs_word_t;

  typedef struct packed {
    dabs_word_t i_word;
    dabs_word_t q_word;
  } dabs_pair_t;

  localparam dabs_pair_t DABS_PAIR_RST = '{i_word: DABS_WORD_RST, q_word: DABS_WORD_RST};

  typedef struct packed {
    logic rise;
    logic fall;
  } dabs_edge_t;

endpackage

// *** dabs_edge_detect.sv ***
// rising and falling edge detector for the conversion clock input
module dabs_edge_detect
  import dabs_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // sampled level
  input wire logic level_in,
  // edges
  output dabs_edge_t edge_out
);

  logic prev_ff;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      prev_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= level_in;
    end
  end

  // input is synchronous to clk_sys, so no synchroniser stage is needed
  assign edge_out.rise = level_in & ~prev_ff;
  assign edge_out.fall = ~level_in & prev_ff;

endmodule

// *** dabs_core.sv ***
// sampling pipeline and output bus arrangement of the dual converter
// ----------------------------------------------------------------
// What this block does
// R1 - one clock times both converter channels
// R2 - both channels sampled on clock falling edge
// R3 - select high: each channel on own bus
// R4 - select low: both channels interleaved on bus one
// R5 - select low: second bus held all low
// R6 - source supplies 1 to 30 MHz clock
// R7 - latency 2.5 cycles, second channel multiplexed 3.0
// R8 - multiplexed: first after rise, second after fall
// R9 - converts every cycle while sleep and idle low
// R10 - each channel word is ten bits
// ----------------------------------------------------------------
module dabs_core
  import dabs_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // conversion clock and controls
  input wire logic conv_clk,
  input wire logic bus_layout_select,
  input wire logic sleep_request,
  input wire logic quick_idle_request,
  // digitised channel inputs
  input wire dabs_pair_t analog_in,
  // output buses
  output dabs_word_t bus_i_ff,
  output dabs_word_t bus_q_ff,
  output logic q_on_bus_ff
);

  // ----------------------------------------------------------------
  // conversion clock edges
  // ----------------------------------------------------------------
  dabs_edge_t conv_edge;
  logic run;

  // a single conversion clock drives both channel pipelines
  dabs_edge_detect u_edge ( // [R1]
    .clk_sys(clk_sys),
    .reset(reset),
    .level_in(conv_clk),
    .edge_out(conv_edge)
  );

  // either low-power request freezes the pipeline; outputs keep the last result, except that a low select still clears the second bus
  assign run = ~sleep_request & ~quick_idle_request; // [R9]

  // ----------------------------------------------------------------
  // qualified edges
  // ----------------------------------------------------------------
  // an edge only counts while the converter is awake
  function automatic logic live_edge(input logic edge_seen, input logic awake);
    live_edge = edge_seen & awake;
  endfunction

  // ----------------------------------------------------------------
  // sampling pipeline
  // ----------------------------------------------------------------
  dabs_pair_t pipe_ff [DABS_PIPE_DEPTH];

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < DABS_PIPE_DEPTH; k++)
      begin
        pipe_ff[k] <= DABS_PAIR_RST;
      end
    end
    else if (run && conv_edge.fall)
    begin
      // both ten-bit words captured together on the same edge
      pipe_ff[0] <= analog_in; // [R2] [R10]
      for (int k = 1; k < DABS_PIPE_DEPTH; k++)
      begin
        pipe_ff[k] <= pipe_ff[k-1]; // [R7]
      end
    end
  end

  // ----------------------------------------------------------------
  // first bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bus_i_ff <= DABS_WORD_RST;
    end
    else if (run && conv_edge.rise)
    begin
      // third rise after sampling: 2.5 periods in both modes
      bus_i_ff <= pipe_ff[DABS_PIPE_LAST].i_word; // [R3] [R7] [R8]
    end
    else if (run && conv_edge.fall && !bus_layout_select)
    begin
      // last stage still holds the word before this shift: 3.0 periods
      bus_i_ff <= pipe_ff[DABS_PIPE_LAST].q_word; // [R4] [R7] [R8]
    end
  end

  // ----------------------------------------------------------------
  // second bus and channel marker
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bus_q_ff <= DABS_BUS_LOW;
    end
    else if (!bus_layout_select)
    begin
      // cleared even while asleep, so the lines stay low all through the mode
      bus_q_ff <= DABS_BUS_LOW; // [R5]
    end
    else if (run && conv_edge.rise)
    begin
      bus_q_ff <= pipe_ff[DABS_PIPE_LAST].q_word; // [R3]
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      q_on_bus_ff <= 1'b0;
    end
    else if (run && conv_edge.rise)
    begin
      q_on_bus_ff <= 1'b0; // [R8]
    end
    else if (run && conv_edge.fall)
    begin
      q_on_bus_ff <= ~bus_layout_select; // [R8]
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_sample_both: assert property (@(posedge clk_sys) disable iff (reset) // [R2]
    run && conv_edge.fall |=> pipe_ff[0] == $past(analog_in))
    else $error("channels not sampled together on falling edge");

  a_pipe_shift: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
    run && conv_edge.fall |=> pipe_ff[1] == $past(pipe_ff[0]) && pipe_ff[2] == $past(pipe_ff[1]))
    else $error("pipeline did not advance");

  a_no_rise_sample: assert property (@(posedge clk_sys) disable iff (reset) // [R2]
    conv_edge.rise |=> $stable(pipe_ff[0]))
    else $error("sample taken on rising edge");

  a_par_i_out: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    run && conv_edge.rise && bus_layout_select
    |=> bus_i_ff == $past(pipe_ff[DABS_PIPE_LAST].i_word) && bus_q_ff == $past(pipe_ff[DABS_PIPE_LAST].q_word))
    else $error("parallel buses not updated on rising edge");

  a_mux_q_out: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    run && conv_edge.fall && !bus_layout_select
    |=> bus_i_ff == $past(pipe_ff[DABS_PIPE_LAST].q_word) && q_on_bus_ff)
    else $error("second channel not placed on first bus");

  a_mux_q_low: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
    !bus_layout_select ##1 !bus_layout_select |-> bus_q_ff == DABS_BUS_LOW)
    else $error("second bus not low in multiplexed mode");

  a_hold_idle: assert property (@(posedge clk_sys) disable iff (reset) // [R9]
    !run |=> $stable(bus_i_ff) && $stable(pipe_ff[0]))
    else $error("outputs changed while idle");

  a_rise_marker: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    run && conv_edge.rise |=> !q_on_bus_ff [*1] ##0 $stable(pipe_ff[0]))
    else $error("marker not cleared after rising edge");

  a_par_fall_hold: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    live_edge(conv_edge.fall, run) && bus_layout_select |=> $stable(bus_i_ff) && !q_on_bus_ff)
    else $error("first bus moved on a falling edge in parallel mode");

  a_q_bus_hold: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    bus_layout_select && !live_edge(conv_edge.rise, run) |=> $stable(bus_q_ff))
    else $error("second bus moved without a rising edge");

  a_mux_i_out: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    live_edge(conv_edge.rise, run) && !bus_layout_select
    |=> bus_i_ff == $past(pipe_ff[DABS_PIPE_LAST].i_word) && !q_on_bus_ff && bus_q_ff == DABS_BUS_LOW)
    else $error("first channel not placed on first bus");

  a_no_edge_hold: assert property (@(posedge clk_sys) disable iff (reset) // [R9]
    !live_edge(conv_edge.rise, run) && !live_edge(conv_edge.fall, run) |=> $stable(bus_i_ff) && $stable(q_on_bus_ff))
    else $error("first bus moved without a live edge");

  a_marker_mux: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    $rose(q_on_bus_ff) |-> !$past(bus_layout_select) && $past(conv_edge.fall) && $past(run))
    else $error("marker raised outside a multiplexed falling edge");

  a_sample_steady: assert property (@(posedge clk_sys) disable iff (reset) // [R2]
    !live_edge(conv_edge.fall, run) |=> $stable(pipe_ff[0]) && $stable(pipe_ff[DABS_PIPE_LAST]))
    else $error("pipeline moved without a falling edge");

  a_shared_clock: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    $past(bus_layout_select) && $changed(bus_q_ff) |-> $past(conv_edge.rise) && $past(run))
    else $error("second bus updated off the shared clock edge");

  a_run_freeze_q: assert property (@(posedge clk_sys) disable iff (reset) // [R9]
    !run && bus_layout_select |=> $stable(bus_q_ff))
    else $error("second bus changed while idle");

  c_par_out: cover property (@(posedge clk_sys) disable iff (reset)
    run && bus_layout_select && conv_edge.rise);

  c_mux_q: cover property (@(posedge clk_sys) disable iff (reset)
    run && !bus_layout_select && conv_edge.fall ##[1:20] conv_edge.rise);

  c_idle_hold: cover property (@(posedge clk_sys) disable iff (reset)
    sleep_request && conv_edge.fall);

  c_mode_switch: cover property (@(posedge clk_sys) disable iff (reset)
    bus_layout_select ##1 !bus_layout_select);

  c_wake_resume: cover property (@(posedge clk_sys) disable iff (reset)
    $fell(quick_idle_request) ##[1:40] run && conv_edge.rise);

endmodule

// *** dabs_capture_model.sv ***
// capture side model: makes the conversion clock and a delayed latch strobe
module dabs_capture_model
  import dabs_pkg::*;
#(
  parameter int unsigned PERIOD = 10
)
(
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // falls count only while the converter runs
  input wire logic count_en,
  // clock out and bench view
  output logic conv_clk,
  output logic [15:0] fall_cnt,
  output logic late_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned ph;
  // 10 system cycles give the rated 20 MHz, inside 1 to 30 MHz
  assign conv_clk = ph < PERIOD / 2;
  // latch 3 cycles after each edge: a delayed clock, safe against bus skew
  assign late_strobe = (ph == 3) || (ph == PERIOD / 2 + 3);
  always @(negedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ph <= 0;
      fall_cnt <= 16'h0000;
    end
    else
    begin
      ph <= (ph == PERIOD - 1) ? 0 : ph + 1;
      if (ph == PERIOD / 2 - 1 && count_en)
        fall_cnt <= fall_cnt + 16'h0001;
    end
  end
endmodule

// *** dual_adc_output_bus_select_tb.sv ***
// self-checking bench for the dual converter output bus block
module dual_adc_output_bus_select_tb;
  import dabs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic bus_layout_select = 1'b1;
  logic sleep_request = 1'b0;
  logic quick_idle_request = 1'b0;
  logic conv_clk;
  logic late_strobe;
  logic [15:0] fall_cnt;
  dabs_pair_t analog_in;
  dabs_word_t bus_i_ff;
  dabs_word_t bus_q_ff;
  logic q_on_bus_ff;
  int errors = 0;
  int n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  function automatic dabs_pair_t pat(input logic [15:0] c);
    pat.i_word = c[9:0] * 10'h025 + 10'h001;
    pat.q_word = ~pat.i_word ^ 10'h155;
  endfunction
  // input word follows the fall count, so it changes with the falling clock
  assign analog_in = pat(fall_cnt);
  dabs_capture_model u_capture (.clk_sys(clk_sys), .reset(reset),
    .count_en(~(sleep_request | quick_idle_request)), .conv_clk(conv_clk),
    .fall_cnt(fall_cnt), .late_strobe(late_strobe));
  dabs_core DUT (.clk_sys(clk_sys), .reset(reset), .conv_clk(conv_clk),
    .bus_layout_select(bus_layout_select), .sleep_request(sleep_request),
    .quick_idle_request(quick_idle_request), .analog_in(analog_in),
    .bus_i_ff(bus_i_ff), .bus_q_ff(bus_q_ff), .q_on_bus_ff(q_on_bus_ff));
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input dabs_word_t seen, input dabs_word_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_strobe();
    int k;
    k = 0;
    @(negedge clk_sys);
    while (late_strobe !== 1'b1 && k < 50)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 50)
    begin
      errors++;
      print_verdict();
    end
  endtask
  // compare buses at each delayed strobe; first words skipped while pipeline fills
  task automatic step(input int n);
    dabs_pair_t w;
    for (int j = 0; j < n; j++)
    begin
      wait_strobe();
      if (fall_cnt >= 16'h0004)
      begin
        w = conv_clk ? pat(fall_cnt - 16'h0002) : pat(fall_cnt - 16'h0003);
        if (conv_clk || bus_layout_select)
          check(bus_i_ff, w.i_word);
        else
          check(bus_i_ff, w.q_word);
        check({9'h000, q_on_bus_ff}, {9'h000, ~conv_clk & ~bus_layout_select});
        if (!bus_layout_select)
          check(bus_q_ff, DABS_BUS_LOW);
        else if (conv_clk)
          check(bus_q_ff, w.q_word);
      end
    end
  endtask
  task automatic t_reset();
    repeat (3) @(negedge clk_sys);
    check(bus_i_ff, DABS_WORD_RST);
    check(bus_q_ff, DABS_WORD_RST);
    check({9'h000, q_on_bus_ff}, 10'h000);
    repeat (3) @(negedge clk_sys);
    reset <= 1'b0;
    $display("test reset done");
  endtask
  task automatic t_stream(input logic sel, input int n);
    bus_layout_select <= sel;
    step(n);
    $display("test stream select=%0d done", sel);
  endtask
  // low-power hold: the buses freeze, and a low select still clears bus two
  task automatic t_hold();
    dabs_word_t hi;
    dabs_word_t hq;
    bus_layout_select <= 1'b1;
    step(4);
    sleep_request <= 1'b1;
    hi = bus_i_ff;
    hq = bus_q_ff;
    repeat (4)
    begin
      wait_strobe();
      check(bus_i_ff, hi);
      check(bus_q_ff, hq);
    end
    bus_layout_select <= 1'b0;
    repeat (2)
    begin
      wait_strobe();
      check(bus_q_ff, DABS_BUS_LOW);
      check(bus_i_ff, hi);
    end
    bus_layout_select <= 1'b1;
    sleep_request <= 1'b0;
    quick_idle_request <= 1'b1;
    repeat (2)
    begin
      wait_strobe();
      check(bus_i_ff, hi);
    end
    quick_idle_request <= 1'b0;
    wait_strobe();
    wait_strobe();
    step(4);
    $display("test hold done");
  endtask
  initial
  begin
    t_reset();
    t_stream(1'b1, 8);
    t_stream(1'b0, 7);
    t_hold();
    t_stream(1'b0, 6);
    print_verdict();
  end
endmodule
